// *** core/lcd_host_write_port.sv ***
// Purpose : host write port of a segment display driver
// Assumes : host pins and the timebase pin are asynchronous to SYS_CLK
// Notes   : busy pin is open drain; it is only ever pulled low

`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [R01] display-off flag blanks panel; sync sets it
// [R02] bus mode: busy low only with select and clear
// [R03] port mode: busy low whenever processing
// [R04] nibble variant drops first nibble with 11 head
// [R05] byte variant pairs bytes by position counter
// [R06] select plus clear zeroes position counter
// [R07] two 11-head bytes resynchronise byte counter
// [R08] four 11-head nibbles resynchronise nibble counter
// [R09] nibble variant orders four nibbles by counter
// [R10] busy undefined twelve timebase clocks after start
// [R11] busy interval 3.5 or 10.5 clocks maximum
// [R12] port mode busy undefined while sync high
// [R13] host clears position counter after power-up
// [R14] busy unsettled until first mode latched
// [R15] standby blanks panel, holds state, halts oscillator
// [R16] standby pauses processing, busy ends after release
// [R17] sync high resets panel drive timing
// [R18] sync sets display-off, clears busy-mode flag
// [R19] host resends mode after every sync
// [R20] host pulses sync after configuring all chips
// [R21] host pulses sync and remodes after standby
// [R22] external-voltage bit selects internal or external supply
// [R23] host waits busy high or clear pulse
// [R24] two-bit duty fields use the shared encoding
// [R25] sync sets external-voltage bit
// [R26] data taken at strobe rise while selected
// [R27] words during busy ignored, counter held
module lcd_host_write_port (
	input  wire logic                              SYS_CLK,
	input  wire logic                              SRST,
	input  wire logic                              CS_N,
	input  wire logic                              WRITE_STROBE_N,
	input  wire logic                              SEQ_CLEAR_N,
	input  wire logic [lcd_port_pkg::BYTE_W-1:0]   HOST_BUS_LINES,
	input  wire logic                              STANDBY_IN,
	input  wire logic                              SYNC_IN,
	input  wire logic                              TIMEBASE_CLOCK,
	input  wire logic                              NIBBLE_VARIANT,
	output logic                                   READY_OUT,
	output logic                                   READY_OE_N,
	output logic                                   PANEL_BLANK,
	output logic                                   OSC_HALT,
	output logic                                   DRIVE_TIMING_RESET,
	output logic [1:0]                             DISPLAY_MODE,
	output logic [1:0]                             DRIVE_MODE,
	output logic                                   BUSY_PORT_MODE,
	output logic                                   EXT_VOLTAGE_SEL,
	output logic                                   RAM_WRITE_STB,
	output logic [1:0]                             RAM_WRITE_KIND,
	output logic [lcd_port_pkg::WORD_W-1:0]        RAM_WRITE_WORD
);

	// ----------------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------------
	lcd_port_pkg::pins_type raw;
	lcd_port_pkg::pins_type s;

	assign raw = {CS_N, WRITE_STROBE_N, SEQ_CLEAR_N, STANDBY_IN, SYNC_IN, TIMEBASE_CLOCK,
		NIBBLE_VARIANT, HOST_BUS_LINES};

	pin_sync #(
		.W       ($bits(lcd_port_pkg::pins_type)),
		.RST_VAL (lcd_port_pkg::PINS_IDLE)
	) u_sync (
		.SYS_CLK (SYS_CLK),
		.SRST    (SRST),
		.d       (raw),
		.q       (s)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic                                 we_prev_q,   we_prev_d;
	logic                                 tb_prev_q,   tb_prev_d;
	logic [1:0]                           pos_q,       pos_d;
	logic [lcd_port_pkg::WORD_W-1:0]      word_q,      word_d;
	logic                                 started_q,   started_d;
	logic [lcd_port_pkg::CNT_W-1:0]       start_cnt_q, start_cnt_d;
	lcd_port_pkg::mode_type               mode_q,      mode_d;
	logic                                 oe_n_q,      oe_n_d;
	logic                                 blank_q,     blank_d;
	logic                                 halt_q,      halt_d;
	logic                                 tres_q,      tres_d;
	logic                                 stb_q,       stb_d;
	logic [1:0]                           kind_q,      kind_d;
	logic [lcd_port_pkg::WORD_W-1:0]      cmd_q,       cmd_d;

	logic                                 we_rise;
	logic                                 tick;
	logic                                 clear;
	logic                                 accept;
	logic                                 head_skip;
	logic [1:0]                           pos_last;
	logic [lcd_port_pkg::WORD_W-1:0]      next_word;
	logic                                 proc_start;
	logic                                 proc_long;
	logic                                 proc_busy;
	logic [lcd_port_pkg::CNT_W-1:0]       proc_remain;
	logic                                 drive_low;

	// pulls the mode fields out of the second half of a mode command
	function automatic lcd_port_pkg::mode_type decode_mode(input logic [lcd_port_pkg::BYTE_W-1:0] b);
		lcd_port_pkg::mode_type m;
		m.display_mode = b[lcd_port_pkg::MODE_DISP_LO +: 2];
		m.display_off  = b[lcd_port_pkg::MODE_OFF_BIT];
		m.drive_mode   = b[lcd_port_pkg::MODE_DRIVE_LO +: 2];
		m.busy_port    = b[lcd_port_pkg::MODE_BUSY_BIT];
		m.ext_voltage  = b[lcd_port_pkg::MODE_EXT_BIT];
		return m;
	endfunction

	// ----------------------------------------------------------------
	// processing interval
	// ----------------------------------------------------------------
	proc_timer u_timer (
		.SYS_CLK (SYS_CLK),
		.SRST    (SRST),
		.start   (proc_start),
		.long_op (proc_long),
		.tick    (tick),
		.busy    (proc_busy),
		.remain  (proc_remain)
	);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		we_prev_d   = s.we_n;
		tb_prev_d   = s.timebase;
		pos_d       = pos_q;
		word_d      = word_q;
		started_d   = started_q;
		start_cnt_d = start_cnt_q;
		mode_d      = mode_q;
		stb_d       = 1'b0;
		kind_d      = kind_q;
		cmd_d       = cmd_q;
		proc_start  = 1'b0;
		proc_long   = 1'b0;

		we_rise   = s.we_n & ~we_prev_q & ~s.cs_n;                 // see [R26]
		tick      = s.timebase & ~tb_prev_q & ~s.standby;          // see [R16]
		clear     = ~s.cs_n & ~s.seq_clear_n;
		accept    = we_rise & ~proc_busy & ~s.standby;             // see [R27] see [R23]
		head_skip = s.nibble ? (s.data[3:2] == lcd_port_pkg::HEAD_SKIP)
			: (s.data[7:6] == lcd_port_pkg::HEAD_SKIP);
		pos_last  = s.nibble ? lcd_port_pkg::POS_LAST_NIB : lcd_port_pkg::POS_LAST_BYTE;
		next_word = s.nibble ? {word_q[11:0], s.data[3:0]} : {word_q[7:0], s.data};

		if (clear)
			pos_d = lcd_port_pkg::POS_FIRST;                       // see [R06]
		else if (accept)
		begin
			// a one-word instruction leaves the counter at the first slot,
			// which is what lets a run of them resynchronise the host
			if (pos_q == lcd_port_pkg::POS_FIRST && head_skip)
				pos_d = lcd_port_pkg::POS_FIRST;                   // see [R04] see [R07] see [R08]
			else if (pos_q == pos_last)
			begin
				pos_d      = lcd_port_pkg::POS_FIRST;              // see [R05] see [R09]
				stb_d      = 1'b1;
				cmd_d      = next_word;
				kind_d     = next_word[lcd_port_pkg::KIND_HI:lcd_port_pkg::KIND_LO];
				proc_start = 1'b1;
				proc_long  = (kind_d == lcd_port_pkg::KIND_DIGIT); // see [R11]
				if (kind_d == lcd_port_pkg::KIND_MODE)
					mode_d = decode_mode(next_word[7:0]);          // see [R22] see [R24] see [R14]
			end
			else
			begin
				pos_d  = pos_q + 2'h1;                             // see [R05] see [R09]
				word_d = next_word;
			end
		end

		// sync overrides display_off, busy_port and ext_voltage of a mode command landing in the same cycle
		if (s.sync)
		begin
			mode_d.display_off = 1'b1;                             // see [R01] see [R18]
			mode_d.busy_port   = 1'b0;                             // see [R18]
			mode_d.ext_voltage = 1'b1;                             // see [R25]
		end

		if (!started_q && tick)
		begin
			start_cnt_d = start_cnt_q + 4'h1;
			if (start_cnt_q == lcd_port_pkg::STARTUP_TICKS - 4'h1)
				started_d = 1'b1;                                  // see [R10]
		end

		// released during start-up and, in port mode, while sync is high, so it never glitches low
		drive_low = started_q & proc_busy
			& (mode_q.busy_port ? ~s.sync : clear);                // see [R02] see [R03] see [R12]
		oe_n_d    = ~drive_low;
		blank_d   = s.standby | mode_q.display_off;                // see [R01] see [R15]
		halt_d    = s.standby;                                     // see [R15]
		tres_d    = s.sync;                                        // see [R17]

		if (SRST)
		begin
			we_prev_d   = 1'b1;
			tb_prev_d   = 1'b0;
			pos_d       = lcd_port_pkg::POS_FIRST;
			word_d      = '0;
			started_d   = 1'b0;
			start_cnt_d = '0;
			mode_d      = lcd_port_pkg::MODE_RST;
			stb_d       = 1'b0;
			kind_d      = lcd_port_pkg::KIND_DIGIT;
			cmd_d       = '0;
			oe_n_d      = 1'b1;
			blank_d     = 1'b1;
			halt_d      = 1'b0;
			tres_d      = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		we_prev_q   <= we_prev_d;
		tb_prev_q   <= tb_prev_d;
		pos_q       <= pos_d;
		word_q      <= word_d;
		started_q   <= started_d;
		start_cnt_q <= start_cnt_d;
		mode_q      <= mode_d;
		stb_q       <= stb_d;
		kind_q      <= kind_d;
		cmd_q       <= cmd_d;
		oe_n_q      <= oe_n_d;
		blank_q     <= blank_d;
		halt_q      <= halt_d;
		tres_q      <= tres_d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK)
	begin
		READY_OUT <= 1'b0;
	end

	assign READY_OE_N         = oe_n_q;
	assign PANEL_BLANK        = blank_q;
	assign OSC_HALT           = halt_q;
	assign DRIVE_TIMING_RESET = tres_q;
	assign DISPLAY_MODE       = mode_q.display_mode;
	assign DRIVE_MODE         = mode_q.drive_mode;
	assign BUSY_PORT_MODE     = mode_q.busy_port;
	assign EXT_VOLTAGE_SEL    = mode_q.ext_voltage;
	assign RAM_WRITE_STB      = stb_q;
	assign RAM_WRITE_KIND     = kind_q;
	assign RAM_WRITE_WORD     = cmd_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SRST);

	sequence s_last_unit;
		accept && !clear && pos_q == pos_last && !(pos_q == lcd_port_pkg::POS_FIRST && head_skip);
	endsequence

	sequence s_mode_cmd;
		s_last_unit ##0 next_word[lcd_port_pkg::KIND_HI:lcd_port_pkg::KIND_LO] == lcd_port_pkg::KIND_MODE;
	endsequence

	property p_sync_mode;
		s.sync |=> mode_q.display_off && !mode_q.busy_port && mode_q.ext_voltage ##1 PANEL_BLANK;
	endproperty
	a_sync_mode: assert property (p_sync_mode) else $error("sync did not force mode flags"); // see [R18]

	property p_bus_low;
		(started_q && proc_busy && !mode_q.busy_port && clear) |=> !READY_OE_N;
	endproperty
	a_bus_low: assert property (p_bus_low) else $error("bus mode busy not driven"); // see [R02]

	property p_bus_release;
		(!mode_q.busy_port && s.cs_n) |=> READY_OE_N;
	endproperty
	a_bus_release: assert property (p_bus_release) else $error("bus mode busy driven without select"); // see [R02]

	property p_port_low;
		(started_q && proc_busy && mode_q.busy_port && !s.sync) |=> !READY_OE_N;
	endproperty
	a_port_low: assert property (p_port_low) else $error("port mode busy not driven"); // see [R03]

	property p_skip_head;
		(accept && !clear && s.nibble && pos_q == lcd_port_pkg::POS_FIRST && head_skip) |=> pos_q == 2'h0;
	endproperty
	a_skip_head: assert property (p_skip_head) else $error("head nibble not discarded"); // see [R04]

	property p_complete;
		s_last_unit |=> pos_q == 2'h0 && RAM_WRITE_STB && proc_busy;
	endproperty
	a_complete: assert property (p_complete) else $error("command not completed at last unit"); // see [R05]

	property p_clear;
		clear |=> pos_q == 2'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("position counter not cleared"); // see [R06]

	property p_startup;
		!started_q |=> READY_OE_N;
	endproperty
	a_startup: assert property (p_startup) else $error("busy driven during startup"); // see [R10]

	property p_long_load;
		(s_last_unit ##0 next_word[15:14] == 2'h0) |=> proc_remain == 4'ha;
	endproperty
	a_long_load: assert property (p_long_load) else $error("digit write interval wrong"); // see [R11]

	property p_sync_release;
		(mode_q.busy_port && s.sync) |=> READY_OE_N;
	endproperty
	a_sync_release: assert property (p_sync_release) else $error("port busy driven during sync"); // see [R12]

	property p_standby;
		s.standby |=> PANEL_BLANK && OSC_HALT;
	endproperty
	a_standby: assert property (p_standby) else $error("standby did not blank and halt"); // see [R15]

	property p_pause;
		(s.standby && proc_busy && !SRST) |=> $stable(proc_remain);
	endproperty
	a_pause: assert property (p_pause) else $error("processing advanced in standby"); // see [R16]

	property p_ext_sel;
		(s_mode_cmd ##0 !s.sync) |=> EXT_VOLTAGE_SEL == $past(next_word[6]);
	endproperty
	a_ext_sel: assert property (p_ext_sel) else $error("external voltage bit not latched"); // see [R22]

	property p_busy_ignore;
		(we_rise && proc_busy && !clear) |=> $stable(pos_q);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("word taken while busy"); // see [R27]

endmodule

`default_nettype wire

// *** core/lcd_port_pkg.sv ***
// Purpose : shared constants and carriers of the display driver host write port
// Assumes : one system clock; the display timebase arrives as a pin
// Notes   : command words are 16 bits in both bus variants

package lcd_port_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int NIB_W  = 4;
	localparam int CNT_W  = 4;

	// ----------------------------------------------------------------
	// command word layout
	// ----------------------------------------------------------------
	localparam int KIND_HI       = 15;
	localparam int KIND_LO       = 14;
	localparam int MODE_DISP_LO  = 0;
	localparam int MODE_OFF_BIT  = 2;
	localparam int MODE_DRIVE_LO = 3;
	localparam int MODE_BUSY_BIT = 5;
	localparam int MODE_EXT_BIT  = 6;

	localparam logic [1:0] KIND_DIGIT = 2'h0;
	localparam logic [1:0] KIND_BIT   = 2'h1;
	localparam logic [1:0] KIND_MODE  = 2'h2;
	localparam logic [1:0] HEAD_SKIP  = 2'h3;

	// display and drive mode encodings
	localparam logic [1:0] DUTY_STATIC  = 2'h0;
	localparam logic [1:0] DUTY_HALF    = 2'h1;
	localparam logic [1:0] DUTY_THIRD   = 2'h2;
	localparam logic [1:0] DUTY_QUARTER = 2'h3;

	// ----------------------------------------------------------------
	// word position counter
	// ----------------------------------------------------------------
	localparam logic [1:0] POS_FIRST     = 2'h0;
	localparam logic [1:0] POS_LAST_BYTE = 2'h1;
	localparam logic [1:0] POS_LAST_NIB  = 2'h3;

	// ----------------------------------------------------------------
	// timing in timebase clocks
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] STARTUP_TICKS = 4'hc;
	localparam logic [CNT_W-1:0] PROC_LONG     = 4'ha;
	localparam logic [CNT_W-1:0] PROC_SHORT    = 4'h3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic       OFF_RST   = 1'h1;
	localparam logic       BUSY_RST  = 1'h0;
	localparam logic       EXT_RST   = 1'h1;
	localparam logic [1:0] DUTY_RST  = 2'h0;

	typedef struct packed {
		logic       ext_voltage;
		logic       busy_port;
		logic [1:0] drive_mode;
		logic       display_off;
		logic [1:0] display_mode;
	} mode_type;

	localparam mode_type MODE_RST = '{ext_voltage: EXT_RST, busy_port: BUSY_RST, drive_mode: DUTY_RST,
		display_off: OFF_RST, display_mode: DUTY_RST};

	typedef struct packed {
		logic              cs_n;
		logic              we_n;
		logic              seq_clear_n;
		logic              standby;
		logic              sync;
		logic              timebase;
		logic              nibble;
		logic [BYTE_W-1:0] data;
	} pins_type;

	localparam pins_type PINS_IDLE = '{cs_n: 1'h1, we_n: 1'h1, seq_clear_n: 1'h1, standby: 1'h0,
		sync: 1'h0, timebase: 1'h0, nibble: 1'h0, data: 8'h00};

endpackage

// *** core/pin_sync.sv ***
// Purpose : two-stage synchroniser for the asynchronous pins
// Assumes : data pins settle long before the strobe edge
// Notes   : all pins pass the same depth so strobe and data stay aligned

`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         SYS_CLK,
	input  wire logic         SRST,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	always_comb
	begin
		meta_d = SRST ? RST_VAL : d;
		q_d    = SRST ? RST_VAL : meta_q;
	end

	always_ff @(posedge SYS_CLK)
	begin
		meta_q <= meta_d;
		q      <= q_d;
	end

endmodule

`default_nettype wire

// *** core/proc_timer.sv ***
// Purpose : internal processing interval counted in timebase clocks
// Assumes : tick is already gated off while the oscillator is halted
// Notes   : a paused count simply holds, so standby stretches the interval

`timescale 1ns/10ps
`default_nettype none

module proc_timer (
	input  wire logic                           SYS_CLK,
	input  wire logic                           SRST,
	input  wire logic                           start,
	input  wire logic                           long_op,
	input  wire logic                           tick,
	output logic                                busy,
	output logic [lcd_port_pkg::CNT_W-1:0]      remain
);

	logic [lcd_port_pkg::CNT_W-1:0] remain_d;

	always_comb
	begin
		remain_d = remain;
		if (start)
			remain_d = long_op ? lcd_port_pkg::PROC_LONG : lcd_port_pkg::PROC_SHORT;
		else if (tick && remain != '0)
			remain_d = remain - 4'h1;
		if (SRST)
			remain_d = '0;
	end

	always_ff @(posedge SYS_CLK)
	begin
		remain <= remain_d;
	end

	assign busy = (remain != '0);

endmodule

`default_nettype wire

// *** verification/host_model.sv ***
// Purpose : behavioural host on the parallel write bus
// Assumes : the caller paces commands on the ready pin or a clear pulse
// Notes   : released data lines are driven to the inverse of the last unit

`timescale 1ns/10ps
`default_nettype none

module host_model (
	input  wire logic       SYS_CLK,
	output logic            CS_N,
	output logic            WRITE_STROBE_N,
	output logic            SEQ_CLEAR_N,
	output logic [7:0]      HOST_BUS_LINES
);
	initial
	begin
		CS_N = 1'h1;
		WRITE_STROBE_N = 1'h1;
		SEQ_CLEAR_N = 1'h1;
		HOST_BUS_LINES = 8'h00;
	end

	// ------
	// one unit: strobe low three clocks, data held three clocks past the rise
	// ------
	task automatic put(input logic [7:0] d);
		@(posedge SYS_CLK);
		CS_N <= 1'h0;
		HOST_BUS_LINES <= d;
		WRITE_STROBE_N <= 1'h0;
		repeat (3) @(posedge SYS_CLK);
		WRITE_STROBE_N <= 1'h1;
		repeat (3) @(posedge SYS_CLK);
		CS_N <= 1'h1;
		HOST_BUS_LINES <= ~d;
	endtask

	// ------
	// select plus clear, also the start-up reset of the word count
	// ------
	task automatic clear(input int cycles);
		@(posedge SYS_CLK);
		CS_N <= 1'h0;
		SEQ_CLEAR_N <= 1'h0;
		repeat (cycles) @(posedge SYS_CLK);
		CS_N <= 1'h1;
		SEQ_CLEAR_N <= 1'h1;
	endtask
endmodule

`default_nettype wire

// *** verification/tb_lcd_host_write_port.sv ***
// Purpose : self-checking bench of the display driver host write port
// Assumes : timebase period of 126 ns, about 16 system clocks a tick
// Notes   : ready pin is pulled up, so a released pin reads 1

`timescale 1ns/10ps
`default_nettype none

module tb_lcd_host_write_port;
	typedef struct {
		logic [7:0] a;
		logic [7:0] b;
		logic [1:0] k;
		int         lim;
	} row_type;

	// ------
	// bytes, kind, busy bound in clocks (3.5 and 10.5 ticks)
	// ------
	row_type     rows [6] = '{'{8'h80, 8'h38, 2'h2, 55}, '{8'h80, 8'h71, 2'h2, 55}, '{8'h80, 8'h2e, 2'h2, 55},
		'{8'h80, 8'h23, 2'h2, 55}, '{8'h45, 8'h12, 2'h1, 55}, '{8'h07, 8'hff, 2'h0, 165}};
	logic        clk;
	logic        srst;
	logic        sb;
	logic        sync;
	logic        tbc;
	logic        nib;
	logic        cs_n, we_n, clr_n, rdy_out, rdy_oe_n, blank, halt, dtr, port, ext, stb, p;
	logic [7:0]  bus;
	logic [1:0]  disp, drv, kind, got_kind;
	logic [15:0] word, got_word;
	int          num_errors = 0;
	int          tests_run = 0;
	int          stb_cnt = 0;
	int          low_len = 0;
	int          busy_len = 0;
	int          busy_runs = 0;
	int          n;
	wire         rdy = (rdy_oe_n === 1'h0) ? rdy_out : 1'h1;

	always #4 clk = ~clk;
	// stand-in oscillator, unrelated in phase to the system clock
	always #63 tbc = ~tbc;

	host_model i_host_model (
		.SYS_CLK        (clk),
		.CS_N           (cs_n),
		.WRITE_STROBE_N (we_n),
		.SEQ_CLEAR_N    (clr_n),
		.HOST_BUS_LINES (bus)
	);

	lcd_host_write_port i_lcd_host_write_port (
		.SYS_CLK            (clk),
		.SRST               (srst),
		.CS_N               (cs_n),
		.WRITE_STROBE_N     (we_n),
		.SEQ_CLEAR_N        (clr_n),
		.HOST_BUS_LINES     (bus),
		.STANDBY_IN         (sb),
		.SYNC_IN            (sync),
		.TIMEBASE_CLOCK     (tbc),
		.NIBBLE_VARIANT     (nib),
		.READY_OUT          (rdy_out),
		.READY_OE_N         (rdy_oe_n),
		.PANEL_BLANK        (blank),
		.OSC_HALT           (halt),
		.DRIVE_TIMING_RESET (dtr),
		.DISPLAY_MODE       (disp),
		.DRIVE_MODE         (drv),
		.BUSY_PORT_MODE     (port),
		.EXT_VOLTAGE_SEL    (ext),
		.RAM_WRITE_STB      (stb),
		.RAM_WRITE_KIND     (kind),
		.RAM_WRITE_WORD     (word)
	);

	always @(posedge clk)
	begin
		if (stb === 1'h1)
		begin
			stb_cnt <= stb_cnt + 1;
			got_kind <= kind;
			got_word <= word;
		end
		if (rdy === 1'h0)
			low_len <= low_len + 1;
		else if (low_len != 0)
		begin
			busy_len <= low_len;
			low_len <= 0;
			busy_runs <= busy_runs + 1;
		end
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// host waits for the ready pin to return high before the next command
	task automatic wait_done();
		int m;
		m = busy_runs;
		repeat (400)
		begin
			@(negedge clk);
			if (busy_runs != m)
				return;
		end
		check("busy_end", 16'h1, 16'h0);
	endtask

	task automatic send(input logic [7:0] a, input logic [7:0] b);
		i_host_model.put(a);
		i_host_model.put(b);
	endtask

	initial
	begin
		clk = 1'h0;
		tbc = 1'h0;
		srst = 1'h1;
		sb = 1'h0;
		sync = 1'h0;
		nib = 1'h0;
		repeat (19) @(negedge clk);
		check("reset", 16'h0602, {ready_pin_n(), blank, halt, dtr, disp, drv, port, ext, stb});
		@(posedge clk);
		srst <= 1'h0;
		repeat (300) @(negedge clk);
		i_host_model.clear(3);
		send(8'h80, 8'h00);
		@(negedge clk);
		check("bus_idle", 16'h1, rdy);
		fork
			i_host_model.clear(8);
			begin
				repeat (6) @(negedge clk);
				check("bus_low", 16'h0, rdy);
			end
		join
		repeat (80) @(negedge clk);
		foreach (rows[i])
		begin
			n = stb_cnt;
			p = port;
			send(rows[i].a, rows[i].b);
			if (p === 1'h1)
				wait_done();
			else
				repeat (80) @(negedge clk);
			check("stb_count", 16'(n + 1), 16'(stb_cnt));
			check("kind", rows[i].k, got_kind);
			check("word", {rows[i].a, rows[i].b}, got_word);
			if (p === 1'h1)
				check("busy_len", 16'h1, busy_len <= rows[i].lim);
			if (rows[i].k == 2'h2)
				check("mode", rows[i].b[6:0], {ext, port, drv, blank, disp});
		end
		// ------
		// awkward cases
		// ------
		n = stb_cnt;
		send(8'h07, 8'h5a);
		i_host_model.put(8'h45);
		wait_done();
		send(8'h45, 8'h33);
		wait_done();
		i_host_model.put(8'h45);
		i_host_model.clear(3);
		send(8'h45, 8'h34);
		wait_done();
		check("clear_word", 16'h4534, got_word);
		send(8'h45, 8'hc0);
		wait_done();
		i_host_model.put(8'hc0);
		send(8'h45, 8'h35);
		wait_done();
		check("resync", 16'h4535, got_word);
		check("cnt_a", 16'(n + 5), 16'(stb_cnt));
		@(posedge clk);
		nib <= 1'h1;
		i_host_model.clear(3);
		n = stb_cnt;
		send(8'h04, 8'h0f);
		send(8'h0f, 8'h0f);
		wait_done();
		i_host_model.put(8'h0f);
		send(8'h04, 8'h05);
		send(8'h01, 8'h02);
		wait_done();
		check("nib_word", 16'h4512, got_word);
		check("cnt_b", 16'(n + 2), 16'(stb_cnt));
		@(posedge clk);
		nib <= 1'h0;
		i_host_model.clear(3);
		n = stb_cnt;
		send(8'h07, 8'h11);
		repeat (20) @(negedge clk);
		@(posedge clk);
		sb <= 1'h1;
		repeat (400) @(negedge clk);
		check("sb_state", 16'h6, {halt, blank, rdy});
		i_host_model.put(8'h45);
		sb <= 1'h0;
		n = 0;
		while (rdy !== 1'h1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		check("sb_release", 16'h1, n <= 170);
		@(posedge clk);
		sync <= 1'h1;
		repeat (4) @(negedge clk);
		check("drive_reset", 16'h1, dtr);
		@(posedge clk);
		sync <= 1'h0;
		repeat (4) @(negedge clk);
		check("sync_mode", 16'h47, {ext, port, drv, blank, disp});
		send(8'h80, 8'h23);
		repeat (80) @(negedge clk);
		check("remode", 16'h23, {ext, port, drv, blank, disp});
		summarize();
	end

	function automatic logic ready_pin_n();
		return rdy_oe_n;
	endfunction

	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		summarize();
	end
endmodule

`default_nettype wire
